/* hdl/gpibrx_pkg.sv */
// Package with constants and types of the listener receive engine
package gpibrx_pkg;
    localparam int CLK_HZ = 25000000;
    localparam int TICK_MS = 55;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam logic [15:0] TMO_DEFAULT_MS = 16'd10000;
    localparam logic [7:0] TERM0_RST = 8'h0a;
    localparam logic [7:0] TERM1_RST = 8'h0d;
    localparam logic [7:0] TERM2_RST = 8'h2c;
    localparam logic [7:0] TERM3_RST = 8'h3b;
    localparam logic [7:0] CHAR_CR = 8'h0d;
    localparam logic [7:0] BUF_MAX = 8'hff;
    localparam logic [4:0] ADDR_MAX = 5'h1e;
    localparam logic [7:0] TALK_BASE = 8'h40;
    localparam logic [7:0] LISTEN_BASE = 8'h20;
    localparam logic [7:0] CMD_UNLISTEN = 8'h3f;
    localparam int ADR_SEL_HI = 7;
    localparam int ADR_SEL_LO = 6;
    localparam int ADR_ZERO_BIT = 5;
    localparam int ST_TMO = 3;
    localparam int ST_OVF = 2;
    localparam int ST_NC = 1;
    localparam int ST_ADRS = 0;
    // Register offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_DMA_TMO = 4'h1;
    localparam logic [3:0] REG_IO_TMO = 4'h2;
    localparam logic [3:0] REG_BOTH_TMO = 4'h3;
    localparam logic [3:0] REG_TERM0 = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam logic [3:0] REG_COUNT = 4'h9;
    localparam logic [3:0] REG_IRQ_STAT = 4'ha;
    localparam logic [3:0] REG_IRQ_MASK = 4'hb;
    localparam logic [3:0] REG_DATA = 4'hc;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ERR = 1;
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_UNL = 3'b001,
        S_TALK = 3'b010,
        S_LISTEN = 3'b011,
        S_RECV = 3'b100,
        S_DONE = 3'b101
    } gpibrx_state_type;
endpackage : gpibrx_pkg

/* hdl/gpibrx_engine.sv */
// Receive engine: addresses a talker, collects bytes, reports count and status
// How it works
// - Message timer flags whole-transfer overrun
// - Timeout ms rounded to nearest 55 ms tick
// - Combined write loads both timeouts
// - Send talk address, then listen ourselves
// - Four terminator bytes, defaults LF CR , ;
// - Addresses 0..30 valid, others rejected
// - End on full, terminator, or EOI
// - Drop CR and terminator bytes
// - Report stored byte count up to 255
// - Status bit 3 on timeout
// - Status bit 2 on buffer full
// - Status bit 1 when not controller
// - Status bit 0 on bad address
// - Both timeouts reset to ten seconds
// - Byte gap timer raises timeout
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
module gpibrx_engine
    import gpibrx_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic is_controller,
    input wire logic [7:0] bus_din,
    input wire logic bus_eoi,
    input wire logic bus_dav,
    output logic bus_atn,
    output logic [7:0] bus_dout,
    output logic bus_cmd_valid,
    input wire logic bus_cmd_ack,
    output logic bus_data_ready,
    output logic irq
);
    function automatic logic [15:0] ms_to_ticks(input logic [15:0] ms);
        logic [16:0] t;
        t = ({1'b0, ms} + 17'(TICK_MS / 2)) / 17'(TICK_MS);
        return t[15:0];
    endfunction : ms_to_ticks

    gpibrx_state_type state_ff;
    logic [15:0] dma_tmo_ff, io_tmo_ff;
    logic [7:0] term_ff [4];
    logic [7:0] addr_ff;
    logic [3:0] status_ff;
    logic [7:0] count_ff;
    logic [7:0] buf_ff [256];
    logic [1:0] irq_stat_ff, irq_mask_ff;
    logic [24:0] presc_ff;
    logic tick_ff;
    logic [15:0] msg_tmr_ff, byte_tmr_ff;
    logic [2:0] dav_sync_ff;
    logic [7:0] din_s1_ff, din_s2_ff;
    logic [1:0] eoi_sync_ff;
    logic ctl_s1_ff, ctl_s2_ff;
    logic [7:0] rd_ptr_ff;
    logic start, byte_strobe, is_term, timeout_hit, done_ev;
    logic [7:0] sel_term;

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dav_sync_ff <= 3'h0;
            din_s1_ff <= 8'h00;
            din_s2_ff <= 8'h00;
            eoi_sync_ff <= 2'h0;
            ctl_s1_ff <= 1'b0;
            ctl_s2_ff <= 1'b0;
        end else begin
            dav_sync_ff <= {dav_sync_ff[1:0], bus_dav};
            din_s1_ff <= bus_din;
            din_s2_ff <= din_s1_ff;
            eoi_sync_ff <= {eoi_sync_ff[0], bus_eoi};
            ctl_s1_ff <= is_controller;
            ctl_s2_ff <= ctl_s1_ff;
        end
    end

    assign byte_strobe = (state_ff == S_RECV) && dav_sync_ff[1] && !dav_sync_ff[2];
    assign start = reg_wr && (reg_addr == REG_CTRL);
    assign sel_term = term_ff[addr_ff[ADR_SEL_HI:ADR_SEL_LO]];
    assign is_term = (din_s2_ff == sel_term);
    assign timeout_hit = (state_ff == S_RECV) && tick_ff &&
        ((msg_tmr_ff >= ms_to_ticks(dma_tmo_ff)) ||
         (byte_tmr_ff >= ms_to_ticks(io_tmo_ff)));
    assign done_ev = (state_ff == S_DONE);

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dma_tmo_ff <= TMO_DEFAULT_MS;
            io_tmo_ff <= TMO_DEFAULT_MS;
            term_ff[0] <= TERM0_RST;
            term_ff[1] <= TERM1_RST;
            term_ff[2] <= TERM2_RST;
            term_ff[3] <= TERM3_RST;
            irq_mask_ff <= 2'h0;
        end else if (reg_wr) begin
            if (reg_addr == REG_DMA_TMO || reg_addr == REG_BOTH_TMO) begin
                dma_tmo_ff <= reg_wdata;
            end
            if (reg_addr == REG_IO_TMO || reg_addr == REG_BOTH_TMO) begin
                io_tmo_ff <= reg_wdata;
            end
            if (reg_addr[3:2] == REG_TERM0[3:2]) begin
                term_ff[reg_addr[1:0]] <= reg_wdata[7:0];
            end
            if (reg_addr == REG_IRQ_MASK) begin
                irq_mask_ff <= reg_wdata[1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // 55 ms prescaler and timers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            presc_ff <= 25'h0;
            tick_ff <= 1'b0;
        end else if (start || presc_ff == 25'(TICK_CYCLES - 1)) begin
            presc_ff <= 25'h0;
            tick_ff <= !start;
        end else begin
            presc_ff <= presc_ff + 25'h1;
            tick_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            msg_tmr_ff <= 16'h0;
            byte_tmr_ff <= 16'h0;
        end else if (state_ff != S_RECV) begin
            msg_tmr_ff <= 16'h0;
            byte_tmr_ff <= 16'h0;
        end else begin
            if (tick_ff && msg_tmr_ff != 16'hffff) begin
                msg_tmr_ff <= msg_tmr_ff + 16'h1;
            end
            if (byte_strobe) begin
                byte_tmr_ff <= 16'h0;
            end else if (tick_ff && byte_tmr_ff != 16'hffff) begin
                byte_tmr_ff <= byte_tmr_ff + 16'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= S_IDLE;
            addr_ff <= 8'h00;
            status_ff <= 4'h0;
            count_ff <= 8'h00;
            bus_atn <= 1'b0;
            bus_dout <= 8'h00;
            bus_cmd_valid <= 1'b0;
            bus_data_ready <= 1'b0;
        end else begin
            unique case (state_ff)
                S_IDLE: begin
                    if (start) begin
                        addr_ff <= reg_wdata[7:0];
                        count_ff <= 8'h00;
                        status_ff <= 4'h0;
                        if (!ctl_s2_ff) begin
                            status_ff[ST_NC] <= 1'b1;
                            state_ff <= S_DONE;
                        end else if (reg_wdata[4:0] > ADDR_MAX ||
                                     reg_wdata[ADR_ZERO_BIT]) begin
                            status_ff[ST_ADRS] <= 1'b1;
                            state_ff <= S_DONE;
                        end else begin
                            bus_atn <= 1'b1;
                            bus_dout <= CMD_UNLISTEN;
                            bus_cmd_valid <= 1'b1;
                            state_ff <= S_UNL;
                        end
                    end
                end
                S_UNL: begin
                    if (bus_cmd_ack) begin
                        bus_dout <= TALK_BASE | {3'h0, addr_ff[4:0]};
                        state_ff <= S_TALK;
                    end
                end
                S_TALK: begin
                    if (bus_cmd_ack) begin
                        bus_dout <= LISTEN_BASE;
                        state_ff <= S_LISTEN;
                    end
                end
                S_LISTEN: begin
                    if (bus_cmd_ack) begin
                        bus_cmd_valid <= 1'b0;
                        bus_atn <= 1'b0;
                        bus_data_ready <= 1'b1;
                        state_ff <= S_RECV;
                    end
                end
                S_RECV: begin
                    if (timeout_hit) begin
                        status_ff[ST_TMO] <= 1'b1;
                        bus_data_ready <= 1'b0;
                        state_ff <= S_DONE;
                    end else if (byte_strobe) begin
                        if (din_s2_ff != CHAR_CR && !is_term) begin
                            if (count_ff == BUF_MAX) begin
                                status_ff[ST_OVF] <= 1'b1;
                                bus_data_ready <= 1'b0;
                                state_ff <= S_DONE;
                            end else begin
                                count_ff <= count_ff + 8'h1;
                            end
                        end
                        if (is_term || eoi_sync_ff[1]) begin
                            bus_data_ready <= 1'b0;
                            state_ff <= S_DONE;
                        end
                    end
                end
                S_DONE: begin
                    state_ff <= S_IDLE;
                end
                default: begin
                    state_ff <= S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (byte_strobe && din_s2_ff != CHAR_CR && !is_term && count_ff != BUF_MAX) begin
            buf_ff[count_ff] <= din_s2_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupts and readback
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_ff <= 2'h0;
            irq <= 1'b0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if ((i == IRQ_DONE && done_ev) || (i == IRQ_ERR && done_ev && status_ff != 4'h0)) begin
                    irq_stat_ff[i] <= 1'b1;
                end else if (reg_wr && reg_addr == REG_IRQ_STAT && reg_wdata[i]) begin
                    irq_stat_ff[i] <= 1'b0;
                end
            end
            irq <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0;
            rd_ptr_ff <= 8'h00;
        end else begin
            if (start) begin
                rd_ptr_ff <= 8'h00;
            end else if (reg_rd && reg_addr == REG_DATA) begin
                rd_ptr_ff <= rd_ptr_ff + 8'h1;
            end
            reg_rdata <= 16'h0;
            if (reg_rd) begin
                unique case (reg_addr)
                    REG_CTRL: reg_rdata <= {8'h00, addr_ff};
                    REG_DMA_TMO, REG_BOTH_TMO: reg_rdata <= dma_tmo_ff;
                    REG_IO_TMO: reg_rdata <= io_tmo_ff;
                    4'h4, 4'h5, 4'h6, 4'h7: reg_rdata <= {8'h00, term_ff[reg_addr[1:0]]};
                    REG_STATUS: reg_rdata <= {11'h0, state_ff != S_IDLE, status_ff};
                    REG_COUNT: reg_rdata <= {8'h00, count_ff};
                    REG_IRQ_STAT: reg_rdata <= {14'h0, irq_stat_ff};
                    REG_IRQ_MASK: reg_rdata <= {14'h0, irq_mask_ff};
                    REG_DATA: reg_rdata <= {8'h00, buf_ff[rd_ptr_ff]};
                    default: reg_rdata <= 16'h0;
                endcase
            end
        end
    end

    AST_NC_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
        (state_ff == S_IDLE && start && !ctl_s2_ff) |=> status_ff[ST_NC] && state_ff == S_DONE)
        else $error("not-controller flag missing");
    AST_BAD_ADDR: assert property (@(posedge clk) disable iff (!rst_n)
        (state_ff == S_IDLE && start && ctl_s2_ff && reg_wdata[4:0] == 5'h1f)
        |=> status_ff[ST_ADRS]) else $error("bad address not flagged");
    AST_TALK_CMD: assert property (@(posedge clk) disable iff (!rst_n)
        (state_ff == S_UNL && bus_cmd_ack) |=> bus_dout == (TALK_BASE | {3'h0, addr_ff[4:0]}))
        else $error("wrong talk command");
    AST_CR_DROP: assert property (@(posedge clk) disable iff (!rst_n)
        (byte_strobe && din_s2_ff == CHAR_CR) |=> $stable(count_ff))
        else $error("CR was stored");
    AST_EOI_END: assert property (@(posedge clk) disable iff (!rst_n)
        (byte_strobe && eoi_sync_ff[1] && !timeout_hit) |=> state_ff == S_DONE)
        else $error("EOI did not end reception");
    AST_OVF: assert property (@(posedge clk) disable iff (!rst_n)
        (byte_strobe && !timeout_hit && count_ff == BUF_MAX && din_s2_ff != CHAR_CR && !is_term)
        |=> status_ff[ST_OVF]) else $error("overflow not flagged");
    AST_TMO: assert property (@(posedge clk) disable iff (!rst_n)
        timeout_hit |=> status_ff[ST_TMO] && state_ff == S_DONE)
        else $error("timeout not flagged");
    AST_BOTH: assert property (@(posedge clk) disable iff (!rst_n)
        (reg_wr && reg_addr == REG_BOTH_TMO) |=> dma_tmo_ff == io_tmo_ff)
        else $error("combined timeout write mismatch");
    AST_COUNT_MAX: assert property (@(posedge clk) disable iff (!rst_n)
        (state_ff == S_RECV && count_ff == BUF_MAX) |=> count_ff == BUF_MAX)
        else $error("count wrapped");
endmodule : gpibrx_engine

/* verif/gpibrx_talker_model.sv */
// Talker instrument model: acknowledges addressing commands, sends queued bytes
`timescale 1ns/1ps
module gpibrx_talker_model (
    input wire logic clk,
    input wire logic bus_cmd_valid,
    input wire logic [7:0] bus_dout,
    input wire logic bus_data_ready,
    output logic bus_cmd_ack,
    output logic [7:0] bus_din,
    output logic bus_eoi,
    output logic bus_dav
);
    logic [7:0] cmds[$];
    logic [8:0] txq[$];
    int ack_wait = 0;
    int cnt = 0;
    logic [8:0] b;
    ////////////////////////////////////////////////////////////
    // Acknowledge each command after ack_wait cycles
    initial begin
        bus_cmd_ack = 1'b0;
        forever begin
            @(posedge clk);
            if (bus_cmd_valid === 1'b1 && !bus_cmd_ack && cnt >= ack_wait) begin
                cmds.push_back(bus_dout);
                bus_cmd_ack <= 1'b1;
                cnt = 0;
            end else begin
                if (bus_cmd_valid === 1'b1 && !bus_cmd_ack) cnt++;
                bus_cmd_ack <= 1'b0;
            end
        end
    end
    // Bytes go out only while the engine listens; data invert once released
    initial begin
        bus_dav = 1'b0;
        bus_din = 8'h00;
        bus_eoi = 1'b0;
        forever begin
            @(posedge clk);
            if (bus_data_ready === 1'b1 && txq.size() > 0) begin
                b = txq.pop_front();
                bus_din <= b[7:0];
                bus_eoi <= b[8];
                bus_dav <= 1'b1;
                repeat (4) @(posedge clk);
                bus_dav <= 1'b0;
                bus_eoi <= 1'b0;
                bus_din <= ~b[7:0];
                repeat (3) @(posedge clk);
            end
        end
    end
endmodule : gpibrx_talker_model

/* verif/gpibrx_engine_tb.sv */
// Self-checking bench of the listener receive engine
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
    $display("[ERR] %0t got %h expected %h", $time, g, e); end end
module gpibrx_engine_tb
    import gpibrx_pkg::*;
;
    typedef struct packed {
        logic [7:0] adr;
        logic [2:0] n;
        logic [31:0] tx;
        logic eoi;
        logic [7:0] cnt;
        logic [31:0] rx;
        logic [4:0] st;
    } gpibrx_row_type;
    logic clk, rst_n, reg_wr, reg_rd, is_controller, bus_eoi, bus_dav, bus_cmd_ack;
    logic bus_atn, bus_cmd_valid, bus_data_ready, irq;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, d;
    logic [7:0] bus_din, bus_dout;
    logic [7:0] terms [4] = '{TERM0_RST, TERM1_RST, TERM2_RST, TERM3_RST};
    gpibrx_row_type rows [6];
    int failures = 0;
    int compares = 0;
    gpibrx_engine gpibrx_engine_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .is_controller(is_controller), .bus_din(bus_din), .bus_eoi(bus_eoi),
        .bus_dav(bus_dav), .bus_atn(bus_atn), .bus_dout(bus_dout),
        .bus_cmd_valid(bus_cmd_valid), .bus_cmd_ack(bus_cmd_ack),
        .bus_data_ready(bus_data_ready), .irq(irq));
    gpibrx_talker_model gpibrx_talker_model_i (.clk(clk), .bus_cmd_valid(bus_cmd_valid),
        .bus_dout(bus_dout), .bus_data_ready(bus_data_ready), .bus_cmd_ack(bus_cmd_ack),
        .bus_din(bus_din), .bus_eoi(bus_eoi), .bus_dav(bus_dav));
    ////////////////////////////////////////////////////////////
    task automatic complete_run();
        if (failures == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask : rd
    task automatic run_row(input gpibrx_row_type r);
        logic [15:0] v;
        int k;
        gpibrx_talker_model_i.cmds.delete();
        for (int i = 0; i < r.n; i++) begin
            gpibrx_talker_model_i.txq.push_back({r.eoi && i == r.n - 1, r.tx[8*i +: 8]});
        end
        wr(REG_CTRL, {8'h00, r.adr});
        k = 0;
        v = 16'h0010;
        while (v[4] !== 1'b0 && k < 5000) begin
            rd(REG_STATUS, v);
            k++;
        end
        repeat (3) @(posedge clk);
        `CHK(v[4:0], r.st)
        `CHK({bus_atn, bus_cmd_valid, bus_data_ready}, 3'h0)
        if (r.st[1:0] == 2'b00) begin
            `CHK(gpibrx_talker_model_i.cmds.size(), 3)
            `CHK(gpibrx_talker_model_i.cmds[0], CMD_UNLISTEN)
            `CHK(gpibrx_talker_model_i.cmds[1], (TALK_BASE | 8'(r.adr[4:0])))
            `CHK(gpibrx_talker_model_i.cmds[2], LISTEN_BASE)
        end else begin
            `CHK(gpibrx_talker_model_i.cmds.size(), 0)
        end
        rd(REG_COUNT, v);
        `CHK(v[7:0], r.cnt)
        for (int i = 0; i < r.cnt; i++) begin
            rd(REG_DATA, v);
            `CHK(v[7:0], r.rx[8*(i%4) +: 8])
        end
    endtask : run_row
    ////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        #800000;
        failures++;
        $display("[ERR] %0t watchdog expired", $time);
        complete_run();
    end
    initial begin
        rst_n = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        is_controller = 1'b1;
        rows[0] = '{8'h07, 3'd4, 32'h0a420d41, 1'b0, 8'd2, 32'h00004241, 5'h00};
        rows[1] = '{8'h4a, 3'd3, 32'h00592c58, 1'b1, 8'd3, 32'h00592c58, 5'h00};
        rows[2] = '{8'h9e, 3'd3, 32'h002c3231, 1'b0, 8'd2, 32'h00003231, 5'h00};
        rows[3] = '{8'hc0, 3'd3, 32'h003b0d51, 1'b0, 8'd1, 32'h00000051, 5'h00};
        rows[4] = '{8'h1f, 3'd0, 32'h0, 1'b0, 8'd0, 32'h0, 5'h01};
        rows[5] = '{8'h25, 3'd0, 32'h0, 1'b0, 8'd0, 32'h0, 5'h01};
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        `CHK({bus_atn, bus_cmd_valid, bus_data_ready, irq}, 4'h0)
        for (int i = 0; i < 6; i++) begin
            gpibrx_talker_model_i.ack_wait = i % 3;
            run_row(rows[i]);
        end
        `CHK(irq, 1'b0)
        // Reset values, unmapped place, combined timeout write
        rd(REG_DMA_TMO, d);
        `CHK(d, TMO_DEFAULT_MS)
        rd(REG_IO_TMO, d);
        `CHK(d, TMO_DEFAULT_MS)
        for (int i = 0; i < 4; i++) begin
            rd(REG_TERM0 + 4'(i), d);
            `CHK(d[7:0], terms[i])
        end
        rd(4'hd, d);
        `CHK(d, 16'h0000)
        wr(REG_BOTH_TMO, 16'd5000);
        rd(REG_DMA_TMO, d);
        `CHK(d, 16'd5000)
        rd(REG_IO_TMO, d);
        `CHK(d, 16'd5000)
        wr(REG_DMA_TMO, 16'd65535);
        rd(REG_IO_TMO, d);
        `CHK(d, 16'd5000)
        wr(REG_IO_TMO, 16'd0);
        rd(REG_IO_TMO, d);
        `CHK(d, 16'd0)
        rd(REG_DMA_TMO, d);
        `CHK(d, 16'd65535)
        // Interrupt raised by unmasking, cleared by writing ones
        wr(REG_IRQ_MASK, 16'h0001);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b1)
        wr(REG_IRQ_STAT, 16'h0003);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b0)
        // Reprogrammed terminator, missing controller role, full buffer
        wr(REG_TERM0, 16'h0021);
        run_row('{8'h03, 3'd2, 32'h00002161, 1'b0, 8'd1, 32'h00000061, 5'h00});
        @(posedge clk);
        is_controller <= 1'b0;
        repeat (4) @(posedge clk);
        run_row('{8'h07, 3'd0, 32'h0, 1'b0, 8'd0, 32'h0, 5'h02});
        @(posedge clk);
        is_controller <= 1'b1;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 256; i++) begin
            gpibrx_talker_model_i.txq.push_back(9'h055);
        end
        run_row('{8'h07, 3'd0, 32'h0, 1'b0, 8'hff, 32'h55555555, 5'h04});
        `CHK(irq, 1'b1)
        // Reset after the full-buffer run brings back default timeouts and terminator 0
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        `CHK({bus_atn, bus_cmd_valid, bus_data_ready, irq}, 4'h0)
        rd(REG_DMA_TMO, d);
        `CHK(d, TMO_DEFAULT_MS)
        rd(REG_IO_TMO, d);
        `CHK(d, TMO_DEFAULT_MS)
        rd(REG_TERM0, d);
        `CHK(d[7:0], TERM0_RST)
        complete_run();
    end
endmodule : gpibrx_engine_tb
